/* pwc_channel.sv */
// Chosen here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pwc_regs.svh"
// Contract
// - Left-aligned counter starts at zero first period after enable, then at one.
// - Update write while counter is zero or one loads value at once; the code holds a period update instead while period is zero.
// - No period update is performed while period value is zero.
// - Disable before one selected-clock period keeps the active flag at one.
module pwc_channel
	import pwc_pkg::*;
(
	// Clock and reset.
	input  wire logic        mclk_i,
	input  wire logic        reset_n_i,
	// Avalon-MM slave.
	input  wire logic [7:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	// Pin towards the shared I/O controller.
	output logic             pwm_o,
	output logic             pwm_oe_o
);

	// ****************************************************************
	// Register state
	// ****************************************************************
	pwc_mode_t   mode_reg,    mode_next;
	logic [15:0] period_reg,  period_next;
	logic [15:0] duty_reg,    duty_next;
	logic [15:0] upd_reg,     upd_next;
	logic        upd_pend_reg, upd_pend_next;
	logic        active_reg,  active_next;
	logic        out_en_reg,  out_en_next;
	logic [15:0] cnt_reg,     cnt_next;
	logic        first_reg,   first_next;
	logic        down_reg,    down_next;
	logic        out_reg,     out_next;
	logic [10:0] div_reg,     div_next;
	logic        ack_reg,     ack_next;
	logic [31:0] rdata_reg,   rdata_next;
	logic        tick_seen_reg, tick_seen_next;
	pwc_state_t  state_reg,   state_next;

	logic        tick;
	logic        wr_en, wr_dis, wr_upd, period_end, cnt_low;

	// The selected clock is a one-cycle enable: prescale N up to 10 gives mclk / 2^N, above 10 no tick at all.
	function automatic logic sel_tick(input logic [10:0] div, input logic [3:0] pre);
		logic [10:0] mask;
		mask = 11'(11'h7FF >> (4'hB - pre));
		sel_tick = (pre > `PWC_PRE_MAX) ? 1'b0 : ((div & mask) == mask);
	endfunction

	// ****************************************************************
	// Decode
	// ****************************************************************
	assign tick       = sel_tick(div_reg, mode_reg.prescale);
	assign wr_en      = avs_write_i && !ack_reg && avs_address_i == `PWC_ENA_OFS;
	assign wr_dis     = avs_write_i && !ack_reg && avs_address_i == `PWC_DIS_OFS;
	assign wr_upd     = avs_write_i && !ack_reg && avs_address_i == `PWC_UPDATE_OFS;
	assign cnt_low    = cnt_reg <= 16'h0001;
	assign period_end = tick && state_reg == PWC_RUN &&
		(mode_reg.center ? (down_reg && cnt_low) : (cnt_reg >= period_reg));

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	always_comb begin
		mode_next      = mode_reg;
		period_next    = period_reg;
		duty_next      = duty_reg;
		upd_next       = upd_reg;
		upd_pend_next  = upd_pend_reg;
		active_next    = active_reg;
		out_en_next    = out_en_reg;
		cnt_next       = cnt_reg;
		first_next     = first_reg;
		down_next      = down_reg;
		state_next     = state_reg;
		tick_seen_next = tick_seen_reg;
		div_next       = 11'(div_reg + 11'h001);
		ack_next       = (avs_read_i || avs_write_i) && !ack_reg;
		rdata_next     = 32'h0000_0000;

		if (avs_read_i && !ack_reg) begin
			case (avs_address_i)
				`PWC_STATE_OFS:   rdata_next = {31'h0, active_reg};
				`PWC_MODE_OFS:    rdata_next = {21'h0, mode_reg.upd_sel, mode_reg.polarity,
				                                mode_reg.center, 4'h0, mode_reg.prescale};
				`PWC_DUTY_OFS:    rdata_next = {16'h0, duty_reg};
				`PWC_PERIOD_OFS:  rdata_next = {16'h0, period_reg};
				`PWC_COUNTER_OFS: rdata_next = {16'h0, cnt_reg};
				default:          rdata_next = 32'h0000_0000;
			endcase
		end
		if (avs_write_i && !ack_reg && !active_reg) begin
			case (avs_address_i)
				`PWC_MODE_OFS: begin
					mode_next.prescale = avs_writedata_i[`PWC_MODE_PRE_LSB +: 4];
					mode_next.center   = avs_writedata_i[`PWC_MODE_ALIGN_BIT];
					mode_next.polarity = avs_writedata_i[`PWC_MODE_POL_BIT];
					mode_next.upd_sel  = avs_writedata_i[`PWC_MODE_UPDSEL_BIT];
				end
				`PWC_DUTY_OFS:   duty_next   = avs_writedata_i[15:0];
				`PWC_PERIOD_OFS: period_next = avs_writedata_i[15:0];
				default: begin
				end
			endcase
		end

		// Update path: immediate on a low counter unless it targets a zero period, otherwise held for period end.
		if (wr_upd) begin
			if (cnt_low && !(mode_reg.upd_sel && period_reg == 16'h0000)) begin
				if (mode_reg.upd_sel)
					period_next = avs_writedata_i[15:0];
				else
					duty_next = avs_writedata_i[15:0];
				upd_pend_next = 1'b0;
			end else begin
				upd_next      = avs_writedata_i[15:0];
				upd_pend_next = 1'b1;
			end
		end else if (period_end && upd_pend_reg) begin
			if (!mode_reg.upd_sel)
				duty_next = upd_reg;
			else if (period_reg != 16'h0000)
				period_next = upd_reg;
			upd_pend_next = mode_reg.upd_sel && period_reg == 16'h0000;
		end

		if (tick)
			tick_seen_next = 1'b1;

		case (state_reg)
			PWC_IDLE: begin
				if (wr_en) begin
					active_next    = 1'b1;
					out_en_next    = 1'b1;
					cnt_next       = 16'h0000;
					first_next     = 1'b1;
					down_next      = 1'b0;
					tick_seen_next = 1'b0;
					div_next       = 11'h000;
					state_next     = PWC_ARMED;
				end
			end
			PWC_ARMED, PWC_RUN: begin
				if (wr_dis) begin
					out_en_next = 1'b0;
					// An early disable stops the line but leaves the flag set.
					if (state_reg == PWC_RUN || tick_seen_reg)
						active_next = 1'b0;
					state_next = PWC_IDLE;
				end else if (tick) begin
					state_next = PWC_RUN;
					if (state_reg == PWC_ARMED) begin
						cnt_next = 16'h0000;
					end else if (mode_reg.center) begin
						if (!down_reg && cnt_reg >= period_reg) begin
							down_next = 1'b1;
							cnt_next  = 16'(cnt_reg - 16'h0001);
						end else if (down_reg && cnt_low) begin
							down_next = 1'b0;
							cnt_next  = 16'(cnt_reg + 16'h0001);
						end else begin
							cnt_next = down_reg ? 16'(cnt_reg - 16'h0001)
							                    : 16'(cnt_reg + 16'h0001);
						end
					end else if (period_end) begin
						cnt_next   = 16'h0001;
						first_next = 1'b0;
					end else begin
						cnt_next = 16'(cnt_reg + 16'h0001);
					end
				end
			end
			default: state_next = PWC_IDLE;
		endcase
		if (wr_en && state_reg != PWC_IDLE)
			active_next = 1'b1;

		out_next = out_en_next && (((cnt_next < duty_next) ^ mode_reg.polarity));
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mode_reg      <= '0;
			period_reg    <= `PWC_PERIOD_RESET;
			duty_reg      <= `PWC_DUTY_RESET;
			upd_reg       <= 16'h0000;
			upd_pend_reg  <= 1'b0;
			active_reg    <= 1'b0;
			out_en_reg    <= 1'b0;
			cnt_reg       <= 16'h0000;
			first_reg     <= 1'b0;
			down_reg      <= 1'b0;
			out_reg       <= 1'b0;
			div_reg       <= 11'h000;
			ack_reg       <= 1'b0;
			rdata_reg     <= 32'h0000_0000;
			tick_seen_reg <= 1'b0;
			state_reg     <= PWC_IDLE;
		end else begin
			mode_reg      <= mode_next;
			period_reg    <= period_next;
			duty_reg      <= duty_next;
			upd_reg       <= upd_next;
			upd_pend_reg  <= upd_pend_next;
			active_reg    <= active_next;
			out_en_reg    <= out_en_next;
			cnt_reg       <= cnt_next;
			first_reg     <= first_next;
			down_reg      <= down_next;
			out_reg       <= out_next;
			div_reg       <= div_next;
			ack_reg       <= ack_next;
			rdata_reg     <= rdata_next;
			tick_seen_reg <= tick_seen_next;
			state_reg     <= state_next;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// Every access takes two cycles: waitrequest drops in the cycle after the request.
	// Read data falls back to zero after its one answer cycle, so a stale word never lingers.
	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_reg;
	assign avs_readdata_o    = rdata_reg;
	assign pwm_o             = out_reg;
	assign pwm_oe_o          = out_en_reg;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);

	first_start_zero_a: assert property (
		wr_en && state_reg == PWC_IDLE |=> cnt_reg == 16'h0000)
		else $error("Counter did not start at zero after enable.");
	restart_one_a: assert property (
		period_end && !mode_reg.center && !wr_dis |=> cnt_reg == 16'h0001)
		else $error("Counter did not restart at one.");
	// Once the first left-aligned period is over, zero never comes back.
	later_nonzero_a: assert property (
		state_reg == PWC_RUN && !first_reg && !mode_reg.center |-> cnt_reg != 16'h0000)
		else $error("Counter returned to zero after the first period.");
	update_now_a: assert property (
		wr_upd && cnt_low && !mode_reg.upd_sel |=> duty_reg == $past(avs_writedata_i[15:0]))
		else $error("Low-counter update was not applied at once.");
	update_period_a: assert property (
		wr_upd && cnt_low && mode_reg.upd_sel && period_reg != 16'h0000
		|=> period_reg == $past(avs_writedata_i[15:0]))
		else $error("Low-counter period update was not applied at once.");
	zero_period_a: assert property (
		period_reg == 16'h0000 && !wr_en && !avs_write_i |=> period_reg == 16'h0000)
		else $error("Period changed while it was zero.");
	defer_update_a: assert property (
		wr_upd && !cnt_low && !period_end && !mode_reg.upd_sel
		|=> upd_pend_reg && $stable(duty_reg))
		else $error("Update was not deferred.");
	// The held value must land on the same edge that closes the period.
	defer_apply_a: assert property (
		period_end && upd_pend_reg && !wr_upd && !mode_reg.upd_sel
		|=> duty_reg == $past(upd_reg))
		else $error("Held update was not applied at period end.");
	// The flag is left set on purpose; only a later timely disable clears it.
	early_disable_a: assert property (
		wr_dis && state_reg == PWC_ARMED && !tick_seen_reg |=> active_reg && !pwm_oe_o)
		else $error("Early disable handled wrongly.");
	enable_flag_a: assert property (wr_en |=> active_reg)
		else $error("Enable did not set the active flag.");
	timely_disable_a: assert property (
		wr_dis && state_reg == PWC_RUN |=> !active_reg ##1 !pwm_o)
		else $error("Timely disable did not clear the flag.");
	bus_answer_a: assert property (avs_read_i && !ack_reg |=> !avs_waitrequest_o)
		else $error("Bus answer late.");
	write_answer_a: assert property (avs_write_i && !ack_reg |=> !avs_waitrequest_o)
		else $error("Write answer late.");

	enable_cov_c: cover property (wr_en ##[1:1000] period_end);
	defer_cov_c: cover property (wr_upd && !cnt_low);
	early_cov_c: cover property (wr_dis && state_reg == PWC_ARMED);
	center_cov_c: cover property (mode_reg.center && period_end);
	immediate_cov_c: cover property (wr_upd && cnt_low);

endmodule
`default_nettype wire

/* pwc_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ********************
// Shared output pin.
// ********************
module pwc_pin_model (
	// Channel and GPIO drivers.
	input  wire logic pwm_i,
	input  wire logic pwm_oe_i,
	input  wire logic gpio_oe_i,
	input  wire logic gpio_val_i,
	// Resolved pin level.
	output logic      pin_o
);
	// An undriven pin falls to its pull-down, so a stale level can never pass a check.
	assign pin_o = pwm_oe_i ? pwm_i : (gpio_oe_i ? gpio_val_i : 1'b0);
endmodule
`default_nettype wire

/* pwc_pkg.sv */
package pwc_pkg;

	typedef struct packed {
		logic       upd_sel;
		logic       polarity;
		logic       center;
		logic [3:0] prescale;
	} pwc_mode_t;

	typedef enum logic [1:0] {
		PWC_IDLE,
		PWC_ARMED,
		PWC_RUN
	} pwc_state_t;

endpackage

/* pwc_regs.svh */
`ifndef PWC_REGS_SVH
`define PWC_REGS_SVH

// ********************************************************************
// Register offsets (byte addresses, one 32-bit word each)
// ********************************************************************
`define PWC_ENA_OFS      8'h00
`define PWC_DIS_OFS      8'h04
`define PWC_STATE_OFS    8'h08
`define PWC_MODE_OFS     8'h0C
`define PWC_DUTY_OFS     8'h10
`define PWC_PERIOD_OFS   8'h14
`define PWC_COUNTER_OFS  8'h18
`define PWC_UPDATE_OFS   8'h1C

// ********************************************************************
// Field positions and reset values
// ********************************************************************
`define PWC_MODE_PRE_LSB     0
`define PWC_MODE_ALIGN_BIT   8
`define PWC_MODE_POL_BIT     9
`define PWC_MODE_UPDSEL_BIT  10
`define PWC_PERIOD_RESET     16'h0001
`define PWC_DUTY_RESET       16'h0001
`define PWC_PRE_MAX          4'hA

`endif

/* test_pulse_width_channel.sv */
`timescale 1ns/1ps
`default_nettype none
module test_pulse_width_channel;
	typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e;} pwc_row_t;
	logic        mclk_i;
	logic        reset_n_i;
	logic [7:0]  avs_address_i;
	logic        avs_read_i;
	logic        avs_write_i;
	logic [31:0] avs_writedata_i;
	logic [31:0] avs_readdata_o;
	logic        avs_waitrequest_o;
	logic        pwm_o;
	logic        pwm_oe_o;
	logic        gpio_oe;
	logic        gpio_val;
	logic        pin;
	logic [31:0] q;
	logic [31:0] seq [5];
	logic [31:0] exp1 [5];
	logic [31:0] exp2 [5];
	pwc_row_t    rows [10];
	int          fails;
	int          n_tests;
	int          k;
	pwc_channel uut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.pwm_o(pwm_o), .pwm_oe_o(pwm_oe_o));
	pwc_pin_model pin_model (.pwm_i(pwm_o), .pwm_oe_i(pwm_oe_o), .gpio_oe_i(gpio_oe),
		.gpio_val_i(gpio_val), .pin_o(pin));
	initial begin
		mclk_i = 1'b0;
		forever #2.5 mclk_i = ~mclk_i;
	end
	// ********************
	// Shared tasks.
	// ********************
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			fails++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// A request is held until waitrequest is seen low, then released at that edge.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		n = 0;
		do begin
			@(posedge mclk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 20);
		q = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		if (avs_waitrequest_o !== 1'b0) begin
			fails++;
			end_of_test();
		end
	endtask
	task automatic wait_cnt(input logic [31:0] v);
		int n;
		n = 0;
		do begin
			bus(1'b0, 8'h18, 32'h0);
			n++;
		end while (q !== v && n < 500);
		if (q !== v) begin
			fails++;
			end_of_test();
		end
	endtask
	// Records the first five counter values, each unlike the one before; a sentinel marks any left unseen.
	task automatic collect();
		seq = '{default: 32'hFFFF_FFFF};
		bus(1'b0, 8'h18, 32'h0);
		seq[0] = q;
		k = 1;
		for (int n = 0; n < 2000 && k < 5; n++) begin
			bus(1'b0, 8'h18, 32'h0);
			if (q !== seq[k-1]) begin
				seq[k] = q;
				k++;
			end
		end
	endtask
	task automatic do_reset();
		reset_n_i <= 1'b0;
		repeat (10) @(posedge mclk_i);
		chk({30'h0, pwm_o, pwm_oe_o}, 32'h0);
		reset_n_i <= 1'b1;
	endtask
	// ********************
	// Main sequence.
	// ********************
	initial begin
		{avs_address_i, avs_read_i, avs_write_i, avs_writedata_i} = '0;
		{gpio_oe, gpio_val, fails, n_tests} = '0;
		reset_n_i = 1'b0;
		exp1 = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h1};
		exp2 = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h2};
		rows = '{'{1'b0, 8'h08, 32'h0, 32'h0}, '{1'b0, 8'h10, 32'h0, 32'h1},
			'{1'b0, 8'h14, 32'h0, 32'h1}, '{1'b0, 8'h18, 32'h0, 32'h0},
			'{1'b0, 8'h0C, 32'h0, 32'h0}, '{1'b1, 8'h14, 32'hFFFF0003, 32'h3},
			'{1'b1, 8'h10, 32'h1, 32'h1}, '{1'b1, 8'h18, 32'h5, 32'h0},
			'{1'b1, 8'h20, 32'h7, 32'h0}, '{1'b1, 8'h0C, 32'h6, 32'h6}};
		do_reset();
		foreach (rows[i]) begin
			if (rows[i].wr) bus(1'b1, rows[i].a, rows[i].d);
			bus(1'b0, rows[i].a, 32'h0);
			chk(q, rows[i].e);
		end
		bus(1'b1, 8'h00, 32'h1);
		bus(1'b0, 8'h08, 32'h0);
		chk(q, 32'h1);
		chk({31'h0, pwm_oe_o}, 32'h1);
		collect();
		foreach (exp1[i]) chk(seq[i], exp1[i]);
		wait_cnt(32'h2);
		bus(1'b1, 8'h1C, 32'h2);
		bus(1'b0, 8'h10, 32'h0);
		chk(q, 32'h1);
		wait_cnt(32'h1);
		bus(1'b0, 8'h10, 32'h0);
		chk(q, 32'h2);
		wait_cnt(32'h3);
		chk({31'h0, pin}, 32'h0);
		wait_cnt(32'h1);
		chk({31'h0, pin}, 32'h1);
		bus(1'b1, 8'h1C, 32'h3);
		bus(1'b0, 8'h10, 32'h0);
		chk(q, 32'h3);
		bus(1'b1, 8'h04, 32'h1);
		bus(1'b0, 8'h08, 32'h0);
		chk(q, 32'h0);
		chk({31'h0, pwm_oe_o}, 32'h0);
		gpio_oe <= 1'b1;
		gpio_val <= 1'b1;
		repeat (2) @(posedge mclk_i);
		chk({31'h0, pin}, 32'h1);
		gpio_oe <= 1'b0;
		// A zero period is programmed here on purpose to see the update refused.
		bus(1'b1, 8'h14, 32'h0);
		bus(1'b1, 8'h0C, 32'h406);
		bus(1'b1, 8'h00, 32'h1);
		bus(1'b1, 8'h1C, 32'h5);
		bus(1'b0, 8'h14, 32'h0);
		chk(q, 32'h0);
		// Long enough for two period ends, so the held update is refused there too.
		repeat (200) @(posedge mclk_i);
		bus(1'b0, 8'h14, 32'h0);
		chk(q, 32'h0);
		bus(1'b1, 8'h04, 32'h1);
		do_reset();
		// Center-aligned and inverted, with updates aimed at the period.
		bus(1'b1, 8'h0C, 32'h703);
		bus(1'b1, 8'h00, 32'h1);
		bus(1'b1, 8'h1C, 32'h3);
		bus(1'b0, 8'h14, 32'h0);
		chk(q, 32'h3);
		collect();
		foreach (exp2[i]) chk(seq[i], exp2[i]);
		wait_cnt(32'h3);
		chk({31'h0, pin}, 32'h1);
		bus(1'b1, 8'h04, 32'h1);
		bus(1'b0, 8'h08, 32'h0);
		chk(q, 32'h0);
		bus(1'b1, 8'h0C, 32'hA);
		bus(1'b1, 8'h00, 32'h1);
		bus(1'b1, 8'h04, 32'h1);
		bus(1'b0, 8'h08, 32'h0);
		chk(q, 32'h1);
		chk({31'h0, pwm_o}, 32'h0);
		end_of_test();
	end
endmodule
`default_nettype wire
